// ===== rtl/haptic_measurement_readback.sv
// serial register slave, trigger handling and resonance/supply tracking
`timescale 1ns/1ps
module haptic_measurement_readback
  import haptic_readback_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = haptic_readback_pkg::SLAVE_ADDR_DEFAULT
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       trigger_input,
  input  wire logic       bemf_cross,
  input  wire logic       playback_busy,
  input  wire logic [7:0] supply_sample,
  input  wire logic       supply_sample_valid,
  output logic            fire_req,
  output logic            cancel_req
);
  import haptic_readback_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE     = 4'b0000,
    S_ADDR     = 4'b0001,
    S_ADDR_ACK = 4'b0010,
    S_PTR      = 4'b0011,
    S_PTR_ACK  = 4'b0100,
    S_WDATA    = 4'b0101,
    S_WACK     = 4'b0110,
    S_RDATA    = 4'b0111,
    S_RACK     = 4'b1000
  } slave_state_t;

  slave_state_t state;
  logic         scl_s;
  logic         sda_s;
  logic         trig_s;
  logic         cross_s;
  logic         scl_q;
  logic         sda_q;
  logic         trig_q;
  logic         cross_q;
  logic         scl_rise;
  logic         scl_fall;
  logic         bus_start;
  logic         bus_stop;
  logic         trig_rise;
  logic         trig_fall;
  logic         crossing;
  logic [3:0]   bit_cnt;
  logic [7:0]   shreg;
  logic [7:0]   tx_byte;
  logic [7:0]   ptr;
  logic         rw;
  logic         mack;
  logic         wr_en;
  logic [7:0]   wr_addr;
  logic [7:0]   wr_data;
  trig_mode_t   mode;
  logic         go;
  logic [7:0]   supply_code;
  logic [7:0]   resonance_period_code;
  logic [8:0]   prescale;
  logic [7:0]   half_cnt;
  logic         seen_first;
  logic [7:0]   rd_now;

  pin_sync3 u_sync_scl   (.clk(clk), .rst_b(rst_b), .pin(scl),           .level(scl_s));
  pin_sync3 u_sync_sda   (.clk(clk), .rst_b(rst_b), .pin(sda_in),        .level(sda_s));
  pin_sync3 u_sync_trig  (.clk(clk), .rst_b(rst_b), .pin(trigger_input), .level(trig_s));
  pin_sync3 u_sync_cross (.clk(clk), .rst_b(rst_b), .pin(bemf_cross),    .level(cross_s));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      trig_q  <= 1'b1;
      cross_q <= 1'b1;
    end else begin
      scl_q   <= scl_s;
      sda_q   <= sda_s;
      trig_q  <= trig_s;
      cross_q <= cross_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_q;
  assign scl_fall  = ~scl_s & scl_q;
  assign bus_start = scl_s & scl_q & sda_q & ~sda_s;
  assign bus_stop  = scl_s & scl_q & ~sda_q & sda_s;
  assign trig_rise = trig_s & ~trig_q;
  assign trig_fall = ~trig_s & trig_q;
  assign crossing  = cross_s ^ cross_q;
  assign sda_out   = 1'b0;

  function automatic logic [7:0] read_reg(input logic [7:0] a);
    case (a)
      MODE_ADDR:   read_reg = {5'h00, mode};
      GO_ADDR:     read_reg = {7'h00, go};
      SUPPLY_ADDR: read_reg = supply_code;
      PERIOD_ADDR: read_reg = resonance_period_code;
      default:     read_reg = READ_UNMAPPED;
    endcase
  endfunction

  // register view at the pointer; a function result cannot be bit-selected
  always_comb begin
    rd_now = read_reg(ptr);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state   <= S_IDLE;
      bit_cnt <= 4'h0;
      shreg   <= 8'h00;
      tx_byte <= 8'h00;
      ptr     <= 8'h00;
      rw      <= 1'b0;
      mack    <= 1'b0;
      sda_oe  <= 1'b0;
      wr_en   <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (bus_start) begin
        state   <= S_ADDR;
        bit_cnt <= 4'h0;
        sda_oe  <= 1'b0;
      end else if (bus_stop) begin
        state  <= S_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          S_ADDR, S_PTR, S_WDATA: begin
            shreg   <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end
          S_RDATA: bit_cnt <= bit_cnt + 4'h1;
          S_RACK:  mack <= ~sda_s;
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state)
          S_ADDR: begin
            if (bit_cnt == BITS_PER_BYTE) begin
              // a foreign address leaves the bus untouched
              if (shreg[7:1] == SLAVE_ADDR) begin
                state  <= S_ADDR_ACK;
                rw     <= shreg[0];
                sda_oe <= 1'b1;
              end else begin
                state <= S_IDLE;
              end
            end
          end
          S_ADDR_ACK: begin
            bit_cnt <= 4'h0;
            if (rw) begin
              state   <= S_RDATA;
              tx_byte <= rd_now;
              sda_oe  <= ~rd_now[7];
            end else begin
              state  <= S_PTR;
              sda_oe <= 1'b0;
            end
          end
          S_PTR: begin
            if (bit_cnt == BITS_PER_BYTE) begin
              ptr    <= shreg;
              state  <= S_PTR_ACK;
              sda_oe <= 1'b1;
            end
          end
          S_WDATA: begin
            if (bit_cnt == BITS_PER_BYTE) begin
              wr_en   <= 1'b1;
              wr_addr <= ptr;
              wr_data <= shreg;
              ptr     <= ptr + 8'h01;
              state   <= S_WACK;
              sda_oe  <= 1'b1;
            end
          end
          S_PTR_ACK, S_WACK: begin
            state   <= S_WDATA;
            bit_cnt <= 4'h0;
            sda_oe  <= 1'b0;
          end
          S_RDATA: begin
            if (bit_cnt == BITS_PER_BYTE) begin
              state  <= S_RACK;
              ptr    <= ptr + 8'h01;
              sda_oe <= 1'b0;
            end else begin
              tx_byte <= {tx_byte[6:0], 1'b0};
              sda_oe  <= ~tx_byte[6];
            end
          end
          S_RACK: begin
            if (mack) begin
              state   <= S_RDATA;
              bit_cnt <= 4'h0;
              tx_byte <= rd_now;
              sda_oe  <= ~rd_now[7];
            end else begin
              state <= S_IDLE;
            end
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end

  // control registers; go clears one clock after it is set, and fires the effect only in internal mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= TRIG_INTERNAL;
      go   <= 1'b0;
    end else begin
      if (wr_en && wr_addr == MODE_ADDR) begin
        mode <= trig_mode_t'(wr_data[MODE_MSB:MODE_LSB]);
      end
      if (wr_en && wr_addr == GO_ADDR && wr_data[GO_BIT]) begin
        go <= 1'b1;
      end else if (go) begin
        go <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fire_req   <= 1'b0;
      cancel_req <= 1'b0;
    end else begin
      case (mode)
        TRIG_INTERNAL: begin
          fire_req   <= go;
          cancel_req <= 1'b0;
        end
        TRIG_EXT_EDGE: begin
          fire_req   <= trig_rise;
          cancel_req <= 1'b0;
        end
        TRIG_EXT_LEVEL: begin
          fire_req   <= trig_rise;
          cancel_req <= trig_fall;
        end
        default: begin
          fire_req   <= 1'b0;
          cancel_req <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      supply_code <= MEASURE_RESET;
    end else if (playback_busy && supply_sample_valid) begin
      supply_code <= supply_sample;
    end else if (wr_en && wr_addr == SUPPLY_ADDR) begin
      supply_code <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prescale <= 9'h000;
      half_cnt <= 8'h00;
    end else if (!playback_busy || crossing) begin
      prescale <= 9'h000;
      half_cnt <= 8'h00;
    end else if (prescale == HALF_LSB_LAST) begin
      prescale <= 9'h000;
      // saturate so a stalled actuator reads as longest period
      if (half_cnt != 8'hFF) begin
        half_cnt <= half_cnt + 8'h01;
      end
    end else begin
      prescale <= prescale + 9'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seen_first            <= 1'b0;
      resonance_period_code <= MEASURE_RESET;
    end else if (!playback_busy) begin
      seen_first <= 1'b0;
      if (wr_en && wr_addr == PERIOD_ADDR) begin
        resonance_period_code <= wr_data;
      end
    end else if (crossing) begin
      seen_first <= 1'b1;
      if (seen_first) begin
        resonance_period_code <= half_cnt;
      end
    end else if (wr_en && wr_addr == PERIOD_ADDR) begin
      resonance_period_code <= wr_data;
    end
  end

  sequence trig_edge_s;
    mode == TRIG_EXT_EDGE && trig_rise;
  endsequence

  sequence fired_s;
    fire_req;
  endsequence

  AST_SUPPLY_CAPTURE: assert property (@(posedge clk) disable iff (!rst_b)
    playback_busy && supply_sample_valid |=> supply_code == $past(supply_sample))
    else $error("supply code not captured");

  AST_IDLE_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    !playback_busy && !wr_en |=> $stable(supply_code) && $stable(resonance_period_code))
    else $error("measurement changed while idle");

  AST_PRESCALE_WRAP: assert property (@(posedge clk) disable iff (!rst_b)
    playback_busy && !crossing && prescale == HALF_LSB_LAST |=> prescale == 9'h000)
    else $error("prescaler did not wrap at one half lsb");

  AST_LOCK: assert property (@(posedge clk) disable iff (!rst_b)
    playback_busy && crossing && seen_first |=> resonance_period_code == $past(half_cnt))
    else $error("period not taken at crossing");

  AST_RETRACK: assert property (@(posedge clk) disable iff (!rst_b)
    playback_busy && crossing |=> half_cnt == 8'h00 && prescale == 9'h000 && seen_first)
    else $error("tracking not restarted at crossing");

  AST_NO_CAL: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(playback_busy) ##0 !crossing [*2] |-> !seen_first)
    else $error("tracking carried state across playbacks");

  AST_EDGE_FIRE: assert property (@(posedge clk) disable iff (!rst_b)
    trig_edge_s |=> fired_s ##1 !fire_req)
    else $error("edge trigger did not fire once");

  AST_TIED_LOW: assert property (@(posedge clk) disable iff (!rst_b)
    mode != TRIG_INTERNAL && !trig_s && !trig_q |=> !fire_req)
    else $error("fired with trigger held low");

  AST_READBACK: assert property (@(posedge clk) disable iff (!rst_b)
    state == S_ADDR_ACK && scl_fall && rw && ptr == SUPPLY_ADDR && !bus_start && !bus_stop
    |=> tx_byte == $past(supply_code))
    else $error("read did not return held supply code");

endmodule

// ===== rtl/haptic_readback_pkg.sv
// constants for the haptic measurement readback block
package haptic_readback_pkg;

  // register offsets
  localparam logic [7:0] MODE_ADDR       = 8'h01;
  localparam logic [7:0] GO_ADDR         = 8'h0C;
  localparam logic [7:0] SUPPLY_ADDR     = 8'h21;
  localparam logic [7:0] PERIOD_ADDR     = 8'h22;

  // reset values and unmapped read value
  localparam logic [7:0] MEASURE_RESET   = 8'h00;
  localparam logic [2:0] MODE_RESET      = 3'h0;
  localparam logic [7:0] READ_UNMAPPED   = 8'h00;

  // field positions
  localparam int         GO_BIT          = 0;
  localparam int         MODE_LSB        = 0;
  localparam int         MODE_MSB        = 2;

  // trigger modes held in the mode register
  typedef enum logic [2:0] {
    TRIG_INTERNAL   = 3'b000,
    TRIG_EXT_EDGE   = 3'b001,
    TRIG_EXT_LEVEL  = 3'b010
  } trig_mode_t;

  // supply code scaling: volts = code * 5.6 V / 255 (software side)
  localparam int         SUPPLY_FULL_MV  = 5600;
  localparam int         SUPPLY_FULL_CODE = 255;

  // period code: one count is 98.46 us, kept in hundredths of a microsecond
  localparam int         PERIOD_LSB_CUS  = 9846;
  localparam int         CLK_PERIOD_NS   = 100;
  // half-cycle timing in half-lsb units gives the full period directly
  localparam int         HALF_LSB_CYCLES = (PERIOD_LSB_CUS * 10) / (2 * CLK_PERIOD_NS);
  localparam logic [8:0] HALF_LSB_LAST   = 9'(HALF_LSB_CYCLES - 1);

  // serial slave
  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h2C;
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

endpackage

// ===== rtl/pin_sync3.sv
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync3 (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic pin,
  output logic      level
);
  logic s1;
  logic s2;
  logic s3;

  // s1 feeds only s2; metastability stays inside the chain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change counts only once the last two stages agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      level <= 1'b1;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end
endmodule

// ===== verif/haptic_measurement_readback_tb.sv
// self-checking bench for the haptic measurement readback block
`timescale 1ns/1ps
module haptic_measurement_readback_tb;
  import haptic_readback_pkg::*;
  logic        clk                 = 1'b0;
  logic        rst_b               = 1'b0;
  logic        trigger_input       = 1'b0;
  logic        bemf_cross          = 1'b0;
  logic        playback_busy       = 1'b0;
  logic [7:0]  supply_sample       = 8'h00;
  logic        supply_sample_valid = 1'b0;
  logic        scl, sda_low, sda, sda_out, sda_oe, fire_req, cancel_req, ok;
  logic [7:0]  rd, exp_sup, exp_per;
  logic [31:0] rnd;
  int          n_fail, checks, n_fire, n_cancel, cyc;

  // pull-up: released line reads high
  assign sda = ~(sda_oe | sda_low);
  always #50 clk = ~clk;

  haptic_measurement_readback #(.SLAVE_ADDR(SLAVE_ADDR_DEFAULT)) u_haptic_measurement_readback (
    .clk                 (clk),
    .rst_b               (rst_b),
    .scl                 (scl),
    .sda_in              (sda),
    .sda_out             (sda_out),
    .sda_oe              (sda_oe),
    .trigger_input       (trigger_input),
    .bemf_cross          (bemf_cross),
    .playback_busy       (playback_busy),
    .supply_sample       (supply_sample),
    .supply_sample_valid (supply_sample_valid),
    .fire_req            (fire_req),
    .cancel_req          (cancel_req)
  );

  serial_host u_serial_host (
    .clk     (clk),
    .sda     (sda),
    .scl     (scl),
    .sda_low (sda_low)
  );

  // count pulses mid-cycle, clear of the edge that launches them
  always @(negedge clk) begin
    if (fire_req === 1'b1) n_fire++;
    if (cancel_req === 1'b1) n_cancel++;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [7:0] exp_code(input int c);
    return (c / HALF_LSB_CYCLES > 255) ? 8'hff : 8'(c / HALF_LSB_CYCLES);
  endfunction

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_ack(input logic got, input logic exp);
    chk_val({7'h00, got}, {7'h00, exp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_serial_host.reg_wr(SLAVE_ADDR_DEFAULT, a, d, ok);
    chk_ack(ok, 1'b1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    u_serial_host.reg_rd(SLAVE_ADDR_DEFAULT, a, rd, ok);
    chk_ack(ok, 1'b1);
    chk_val(rd, e);
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    tick(95000);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    rnd = 32'h9a4c_ec04;
    tick(10);
    rst_b = 1'b1;
    tick(10);
    rd_chk(SUPPLY_ADDR, MEASURE_RESET);
    rd_chk(PERIOD_ADDR, MEASURE_RESET);
    rd_chk(8'h40, READ_UNMAPPED);
    u_serial_host.reg_wr(SLAVE_ADDR_DEFAULT ^ 7'h01, MODE_ADDR, 8'h01, ok);
    chk_ack(ok, 1'b0);
    rd_chk(MODE_ADDR, 8'h00);
    chk_val({7'h00, sda_out}, 8'h00);
    chk_val(8'(n_fire + n_cancel), 8'h00);
    $display("test idle done");
    // each trigger mode and one undefined code: pin pulse, then a go write
    for (int m = 0; m < 4; m++) begin
      wr(MODE_ADDR, 8'(m));
      rd_chk(MODE_ADDR, 8'(m));
      n_fire = 0;
      n_cancel = 0;
      rnd = lfsr(rnd);
      trigger_input = 1'b1;
      tick(12 + int'(rnd[3:0]));
      trigger_input = 1'b0;
      tick(20);
      chk_val(8'(n_fire), (m == 1 || m == 2) ? 8'h01 : 8'h00);
      chk_val(8'(n_cancel), (m == 2) ? 8'h01 : 8'h00);
      wr(GO_ADDR, 8'h01);
      tick(5);
      chk_val(8'(n_fire), (m < 3) ? 8'h01 : 8'h00);
    end
    $display("test trigger done");
    exp_sup = 8'ha5;
    wr(SUPPLY_ADDR, exp_sup);
    // samples outside playback must be ignored
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      playback_busy = k[0];
      supply_sample = rnd[7:0];
      supply_sample_valid = 1'b1;
      tick(1);
      supply_sample_valid = 1'b0;
      tick(2);
      if (k[0]) exp_sup = rnd[7:0];
      playback_busy = 1'b0;
      rd_chk(SUPPLY_ADDR, exp_sup);
    end
    $display("test supply done");
    wr(PERIOD_ADDR, 8'h5a);
    rd_chk(PERIOD_ADDR, 8'h5a);
    playback_busy = 1'b1;
    tick(3);
    // half-tick offset keeps the crossing clear of a count boundary
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      cyc = (3 + int'(rnd[2:0])) * HALF_LSB_CYCLES + HALF_LSB_CYCLES / 2;
      bemf_cross = ~bemf_cross;
      tick(cyc);
      bemf_cross = ~bemf_cross;
      tick(8);
      exp_per = exp_code(cyc);
      rd_chk(PERIOD_ADDR, exp_per);
    end
    playback_busy = 1'b0;
    tick(4);
    bemf_cross = ~bemf_cross;
    tick(3 * HALF_LSB_CYCLES);
    bemf_cross = ~bemf_cross;
    tick(8);
    rd_chk(PERIOD_ADDR, exp_per);
    $display("test period done");
    tally_and_finish();
  end
endmodule

// ===== verif/serial_host.sv
// host model: open-drain serial master for the register port
`timescale 1ns/1ps
module serial_host (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // ten clocks a phase keeps well above the slave's sync delay
  localparam int PH = 10;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask

  // data moves two clocks after scl falls, never in the same step
  task automatic bit_io(input logic b, output logic r);
    w(2);
    sda_low = ~b;
    w(PH);
    scl = 1'b1;
    w(PH);
    r = sda;
    scl = 1'b0;
  endtask

  task automatic byte_io(input logic [7:0] b, input logic m, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r[i]);
    bit_io(m, a);
    ack = ~a;
  endtask

  task automatic start();
    w(2);
    sda_low = 1'b0;
    w(PH);
    scl = 1'b1;
    w(PH);
    sda_low = 1'b1;
    w(PH);
    scl = 1'b0;
  endtask

  task automatic stop();
    w(2);
    sda_low = 1'b1;
    w(PH);
    scl = 1'b1;
    w(PH);
    sda_low = 1'b0;
    w(PH);
  endtask

  task automatic reg_wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic       a0, a1, a2;
    start();
    byte_io({dev, 1'b0}, 1'b1, r, a0);
    byte_io(a, 1'b1, r, a1);
    byte_io(d, 1'b1, r, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask

  // pointer write, repeated start, one byte closed by a nack
  task automatic reg_rd(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic       a0, a1, a2, a3;
    start();
    byte_io({dev, 1'b0}, 1'b1, r, a0);
    byte_io(a, 1'b1, r, a1);
    start();
    byte_io({dev, 1'b1}, 1'b1, r, a2);
    byte_io(8'hff, 1'b1, d, a3);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule
